//--- rtl/ptbp_port_ctrl.v
// port pin control, pin interrupt logic and register slave
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ptbp_defines.vh"
module ptbp_port_ctrl #(
    parameter WIDTH = 8,
    parameter [7:0] SLEW_RESET = `PTBP_RST_SLEW
) (
    input wire clk,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire [WIDTH-1:0] pin_in,
    input wire [WIDTH-1:0] direction_bits,
    output reg [WIDTH-1:0] pull_up_en,
    output reg [WIDTH-1:0] pull_down_en,
    output reg [WIDTH-1:0] slew_en,
    output reg [WIDTH-1:0] drive_high,
    output reg irq
);
    function hit;
        input [2:0] addr;
        input [2:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    reg [WIDTH-1:0] pull_enable_bits;
    reg [WIDTH-1:0] slew_enable_bits;
    reg [WIDTH-1:0] drive_select_bits;
    reg [WIDTH-1:0] pin_irq_select_bits;
    reg [WIDTH-1:0] pin_edge_select_bits;
    reg pin_irq_flag;
    reg pin_irq_enable;
    reg pin_detect_mode;
    reg [1:0] evt_status;
    reg [1:0] evt_mask;
    reg [7:0] next_rdata;
    reg next_flag;
    reg [1:0] next_evt;
    wire [WIDTH-1:0] pin_sync;
    wire edge_hit;
    wire level_hit;
    wire wr_pull;
    wire wr_slew;
    wire wr_drive;
    wire wr_sc;
    wire wr_psel;
    wire wr_esel;
    wire wr_evtmask;
    wire rd_evt;
    wire ack_write;
    wire flag_set;
    wire flag_clear;
    wire ack_held;
    wire [WIDTH-1:0] is_input;
    wire [WIDTH-1:0] down_wanted;
    wire next_ie;
    wire [1:0] next_mask;

    assign wr_pull = reg_wr & hit(reg_addr, `PTBP_OFF_PULL);
    assign wr_slew = reg_wr & hit(reg_addr, `PTBP_OFF_SLEW);
    assign wr_drive = reg_wr & hit(reg_addr, `PTBP_OFF_DRIVE);
    assign wr_sc = reg_wr & hit(reg_addr, `PTBP_OFF_SC);
    assign wr_psel = reg_wr & hit(reg_addr, `PTBP_OFF_PSEL);
    assign wr_esel = reg_wr & hit(reg_addr, `PTBP_OFF_ESEL);
    assign wr_evtmask = reg_wr & hit(reg_addr, `PTBP_OFF_EVTMASK);
    assign rd_evt = reg_rd & hit(reg_addr, `PTBP_OFF_EVT);

    // pins come from outside the clock domain
    ptbp_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    ptbp_detect #(
        .WIDTH(WIDTH)
    ) u_detect (
        .clk(clk),
        .rst_n(rst_n),
        .pin_level(pin_sync),
        .pin_irq_select_bits(pin_irq_select_bits),
        .pin_edge_select_bits(pin_edge_select_bits),
        .pin_detect_mode(pin_detect_mode),
        .edge_hit(edge_hit),
        .level_hit(level_hit)
    );

    // pull register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_enable_bits <= `PTBP_RST_PULL;
        end else if (wr_pull) begin
            pull_enable_bits <= reg_wdata[WIDTH-1:0];
        end
    end

    // reset value is a parameter: software must not rely on it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_enable_bits <= SLEW_RESET;
        end else if (wr_slew) begin
            slew_enable_bits <= reg_wdata[WIDTH-1:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_select_bits <= `PTBP_RST_DRIVE;
        end else if (wr_drive) begin
            drive_select_bits <= reg_wdata[WIDTH-1:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_irq_select_bits <= `PTBP_RST_PSEL;
        end else if (wr_psel) begin
            pin_irq_select_bits <= reg_wdata[WIDTH-1:0];
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_edge_select_bits <= `PTBP_RST_ESEL;
        end else if (wr_esel) begin
            pin_edge_select_bits <= reg_wdata[WIDTH-1:0];
        end
    end

    // control bits of the status and control register
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_irq_enable <= 1'b0;
            pin_detect_mode <= 1'b0;
        end else if (wr_sc) begin
            pin_irq_enable <= reg_wdata[`PTBP_SC_IE];
            pin_detect_mode <= reg_wdata[`PTBP_SC_MODE];
        end
    end

    // acknowledge is a write-only strobe, never stored
    assign ack_write = wr_sc & reg_wdata[`PTBP_SC_ACK];
    assign flag_set = edge_hit | level_hit;
    // in level mode an active level keeps the flag up
    assign ack_held = ack_write & level_hit;
    assign flag_clear = ack_write & ~level_hit;

    // set wins over the ack so a coincident event is kept
    always @* begin
        next_flag = pin_irq_flag;
        if (flag_clear) begin
            next_flag = 1'b0;
        end
        if (flag_set) begin
            next_flag = 1'b1;
        end
    end

    // written data never reaches the flag itself
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_irq_flag <= 1'b0;
        end else begin
            pin_irq_flag <= next_flag;
        end
    end

    // sticky events, cleared by reading them; a new event wins
    always @* begin
        next_evt = evt_status;
        if (rd_evt) begin
            next_evt = 2'h0;
        end
        if (flag_set) begin
            next_evt[`PTBP_EVT_DETECT] = 1'b1;
        end
        if (ack_held) begin
            next_evt[`PTBP_EVT_ACK_HELD] = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_status <= `PTBP_RST_EVT;
            evt_mask <= `PTBP_RST_EVTMASK;
        end else begin
            evt_status <= next_evt;
            if (wr_evtmask) begin
                evt_mask <= reg_wdata[1:0];
            end
        end
    end

    // read data, one cycle after the strobe, zero otherwise
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `PTBP_OFF_PULL: begin
                    next_rdata = pull_enable_bits;
                end
                `PTBP_OFF_SLEW: begin
                    next_rdata = slew_enable_bits;
                end
                `PTBP_OFF_DRIVE: begin
                    next_rdata = drive_select_bits;
                end
                `PTBP_OFF_SC: begin
                    // ack and upper bits read zero
                    next_rdata[`PTBP_SC_FLAG] = pin_irq_flag;
                    next_rdata[`PTBP_SC_IE] = pin_irq_enable;
                    next_rdata[`PTBP_SC_MODE] = pin_detect_mode;
                end
                `PTBP_OFF_PSEL: begin
                    next_rdata = pin_irq_select_bits;
                end
                `PTBP_OFF_ESEL: begin
                    next_rdata = pin_edge_select_bits;
                end
                `PTBP_OFF_EVT: begin
                    next_rdata[1:0] = evt_status;
                end
                `PTBP_OFF_EVTMASK: begin
                    next_rdata[1:0] = evt_mask;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // pad controls; direction 1 means driver on
    assign is_input = ~direction_bits;
    // pull-down only for a selected pin with rising/high polarity
    assign down_wanted = pin_irq_select_bits & pin_edge_select_bits;

    // outputs registered, so pad settings lag the registers by a cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pull_up_en <= {WIDTH{1'b0}};
            pull_down_en <= {WIDTH{1'b0}};
            slew_en <= {WIDTH{1'b0}};
            drive_high <= {WIDTH{1'b0}};
        end else begin
            // outputs never see a pull
            pull_up_en <= pull_enable_bits & is_input & ~down_wanted;
            pull_down_en <= pull_enable_bits & is_input & down_wanted;
            // inputs ignore slew and drive
            slew_en <= slew_enable_bits & direction_bits;
            drive_high <= drive_select_bits & direction_bits;
        end
    end

    // next values, so the request moves in the same cycle as the registers
    assign next_ie = wr_sc ? reg_wdata[`PTBP_SC_IE] : pin_irq_enable;
    assign next_mask = wr_evtmask ? reg_wdata[1:0] : evt_mask;

    // request follows flag and enable; event mask adds the sticky events
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (next_flag & next_ie) | (|(next_evt & next_mask));
        end
    end
endmodule // ptbp_port_ctrl
`default_nettype wire

//--- rtl/ptbp_defines.vh
// register map, field positions and reset values of the port pin control block
// Behaviour
// - pull bit 1 enables pin pull device
// - output pins never get a pull
// - pull-down only on selected rising-polarity irq pins
// - slew bit 1 enables output slew control
// - slew and drive ignored on input pins
// - drive bit selects low or high strength
// - flag set on detect, writes ignored
// - ack write clears flag, reads zero; in mode 1 an active selected level keeps the flag set
// - enable bit gates the interrupt request; masked sticky events bypass it
// - mode bit: edges only, or edges and levels
// - pin select bit enables pin as source
// - edge select 0: pull-up, falling or low
// - edge select 1: pull-down, rising or high
// - direction bit 1 makes pin an output
// - reset leaves pins input, pulls disabled
`ifndef PTBP_DEFINES_VH
`define PTBP_DEFINES_VH
`define PTBP_ADDR_W 3
`define PTBP_OFF_PULL 3'h0
`define PTBP_OFF_SLEW 3'h1
`define PTBP_OFF_DRIVE 3'h2
`define PTBP_OFF_SC 3'h3
`define PTBP_OFF_PSEL 3'h4
`define PTBP_OFF_ESEL 3'h5
`define PTBP_OFF_EVT 3'h6
`define PTBP_OFF_EVTMASK 3'h7
`define PTBP_SC_FLAG 3
`define PTBP_SC_ACK 2
`define PTBP_SC_IE 1
`define PTBP_SC_MODE 0
`define PTBP_EVT_DETECT 0
`define PTBP_EVT_ACK_HELD 1
`define PTBP_RST_PULL 8'h00
`define PTBP_RST_SLEW 8'h00
`define PTBP_RST_DRIVE 8'h00
`define PTBP_RST_SC 8'h00
`define PTBP_RST_PSEL 8'h00
`define PTBP_RST_ESEL 8'h00
`define PTBP_RST_EVT 2'h0
`define PTBP_RST_EVTMASK 2'h0
`endif

//--- rtl/ptbp_sync.v
// two-stage synchroniser for the pin levels
`timescale 1ns/1ns
`default_nettype none
module ptbp_sync #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    // stage1 feeds only stage two, nothing else looks at it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ptbp_sync
`default_nettype wire

//--- rtl/ptbp_detect.v
// per-pin edge and level detection for the port interrupt
`timescale 1ns/1ns
`default_nettype none
module ptbp_detect #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire rst_n,
    input wire [WIDTH-1:0] pin_level,
    input wire [WIDTH-1:0] pin_irq_select_bits,
    input wire [WIDTH-1:0] pin_edge_select_bits,
    input wire pin_detect_mode,
    output wire edge_hit,
    output wire level_hit
);
    reg [WIDTH-1:0] prev_level;
    wire [WIDTH-1:0] rise;
    wire [WIDTH-1:0] fall;
    wire [WIDTH-1:0] edge_sel;
    wire [WIDTH-1:0] level_sel;

    // prev reset low: a pin already high at release shows a rise once it has
    // passed the synchroniser; first sample is taken right after reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_level <= {WIDTH{1'b0}};
        end else begin
            prev_level <= pin_level;
        end
    end

    assign rise = pin_level & ~prev_level;
    assign fall = ~pin_level & prev_level;
    // polarity from the edge select bits
    assign edge_sel = (pin_edge_select_bits & rise) | (~pin_edge_select_bits & fall);
    assign level_sel = (pin_edge_select_bits & pin_level) | (~pin_edge_select_bits & ~pin_level);
    // unselected pins contribute nothing
    assign edge_hit = |(pin_irq_select_bits & edge_sel);
    // levels count only in mode 1
    assign level_hit = pin_detect_mode & (|(pin_irq_select_bits & level_sel));
endmodule // ptbp_detect
`default_nettype wire

//--- verif/ptbp_pin_model.sv
// pin-side model: driven levels, pulls, floating pins
`timescale 1ns/1ns
`default_nettype none
module ptbp_pin_model (
    input wire logic clk,
    input wire logic [7:0] pin_drv,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up_en,
    input wire logic [7:0] pull_down_en,
    output logic [7:0] pin_in
);
    logic [7:0] flt = 8'h55;
    // a floating pin wanders, so no settled level can be relied on
    always @(posedge clk) flt <= ~flt;
    assign pin_in = (pin_oe & pin_drv) | (~pin_oe & pull_up_en)
        | (~pin_oe & ~pull_up_en & ~pull_down_en & flt);
endmodule // ptbp_pin_model
`default_nettype wire

//--- verif/ptbp_port_ctrl_properties.sv
// port control assertions and their bind
`timescale 1ns/1ns
`default_nettype none
module ptbp_port_ctrl_checker #(
    parameter WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] direction_bits,
    input wire logic [WIDTH-1:0] pull_up_en,
    input wire logic [WIDTH-1:0] pull_down_en,
    input wire logic [WIDTH-1:0] slew_en,
    input wire logic [WIDTH-1:0] drive_high,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [WIDTH-1:0] last_pin;
    logic [2:0] calm;
    logic mode_seen;
    logic [1:0] mask_seen;
    // pin quiet time, so a pending detection cannot mask an ack
    // mode and event mask shadows: the ports do not show them
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pin <= '0;
            calm <= 3'h0;
            mode_seen <= 1'b0;
            mask_seen <= 2'h0;
        end else begin
            last_pin <= pin_in;
            calm <= (pin_in != last_pin) ? 3'h0 : ((calm == 3'h7) ? calm : calm + 3'h1);
            if (reg_wr && reg_addr == 3'h3) begin
                mode_seen <= reg_wdata[0];
            end
            if (reg_wr && reg_addr == 3'h7) begin
                mask_seen <= reg_wdata[1:0];
            end
        end
    end
    property p_no_pull_out;
        ((pull_up_en | pull_down_en) & $past(direction_bits)) == '0;
    endproperty
    a_no_pull_out: assert property (p_no_pull_out) else $error("pull on output pin");
    property p_pad_input;
        ((slew_en | drive_high) & ~$past(direction_bits)) == '0;
    endproperty
    a_pad_input: assert property (p_pad_input) else $error("pad control on input");
    property p_pull_reg;
        reg_wr && reg_addr == 3'h0 |-> ##2
            (pull_up_en | pull_down_en) == ($past(reg_wdata, 2) & ~$past(direction_bits));
    endproperty
    a_pull_reg: assert property (p_pull_reg) else $error("pull without enable bit");
    property p_slew_reg;
        reg_wr && reg_addr == 3'h1 |-> ##2
            slew_en == ($past(reg_wdata, 2) & $past(direction_bits));
    endproperty
    a_slew_reg: assert property (p_slew_reg) else $error("slew without enable bit");
    property p_drive_reg;
        reg_wr && reg_addr == 3'h2 |-> ##2
            drive_high == ($past(reg_wdata, 2) & $past(direction_bits));
    endproperty
    a_drive_reg: assert property (p_drive_reg) else $error("high drive not selected");
    property p_sc_read;
        reg_rd && reg_addr == 3'h3 |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2];
    endproperty
    a_sc_read: assert property (p_sc_read) else $error("status read bits wrong");
    property p_ie_off;
        reg_wr && reg_addr == 3'h3 && !reg_wdata[1] && mask_seen == 2'h0 |=> !irq;
    endproperty
    a_ie_off: assert property (p_ie_off) else $error("request while disabled");
    property p_ack_clear;
        reg_wr && reg_addr == 3'h3 && reg_wdata[2:0] == 3'h6 && calm >= 3'h4 && !mode_seen
            && mask_seen == 2'h0 |=> !irq;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack left request");
    c_irq: cover property ($rose(irq));
    c_ack: cover property (reg_wr && reg_addr == 3'h3 && reg_wdata[2]);
    c_rd: cover property (reg_rd && reg_addr == 3'h6);
endmodule // ptbp_port_ctrl_checker
bind ptbp_port_ctrl ptbp_port_ctrl_checker #(.WIDTH(WIDTH)) chk (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .direction_bits(direction_bits),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .slew_en(slew_en),
    .drive_high(drive_high), .irq(irq));
`default_nettype wire

//--- verif/port_b_pin_control_irq_bench.sv
// self-checking bench of the port control block
`timescale 1ns/1ns
`default_nettype none
module port_b_pin_control_irq_bench;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, pin_in, direction_bits = 8'h00;
    logic [7:0] pin_drv = 8'h00, pin_oe = 8'hff, pu, pd, sl, dr;
    int error_cnt = 0, checked = 0;
    // pull slew drive psel esel dir | pull_up pull_down slew drive
    logic [79:0] rows [4] = '{80'hff0000000000ff000000, 80'hffffff0f33c03c03c0c0,
        80'h5aa53cffff0f0050050c, 80'h00ff00ff00ff0000ff00};
    initial forever #20 clk = ~clk;
    ptbp_port_ctrl uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .direction_bits(direction_bits), .pull_up_en(pu), .pull_down_en(pd),
        .slew_en(sl), .drive_high(dr), .irq(irq));
    ptbp_pin_model pins (.clk(clk), .pin_drv(pin_drv), .pin_oe(pin_oe), .pull_up_en(pu),
        .pull_down_en(pd), .pin_in(pin_in));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // pin change, then past the two sync flops and the flag
    task automatic pin_to(input logic [7:0] v);
        @(posedge clk);
        pin_drv <= v;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #200000 error_cnt++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(pu | pd | sl | dr, 8'h00);
        for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
        wr(3'h1, 8'h00);
        foreach (rows[i]) begin
            for (int a = 0; a < 5; a++) wr(3'(a + a / 3), rows[i][79-8*a -: 8]);
            @(posedge clk);
            direction_bits <= rows[i][39:32];
            repeat (3) @(posedge clk);
            #1 chk(pu, rows[i][31:24]);
            chk(pd, rows[i][23:16]);
            chk(sl, rows[i][15:8]);
            chk(dr, rows[i][7:0]);
            rd(3'h0, rows[i][79:72]);
        end
        rd(3'h6, 8'h00);
        wr(3'h3, 8'h04);
        direction_bits <= 8'h00;
        pin_drv <= 8'hff;
        wr(3'h4, 8'h01);
        wr(3'h5, 8'h00);
        pin_to(8'hff);
        wr(3'h3, 8'h0e);
        pin_to(8'hfd);
        chk(irq, 8'h00);
        pin_to(8'hfc);
        chk(irq, 8'h01);
        rd(3'h3, 8'h0a);
        wr(3'h3, 8'h0e);
        #1 chk(irq, 8'h00);
        rd(3'h3, 8'h02);
        wr(3'h5, 8'h01);
        wr(3'h3, 8'h00);
        pin_to(8'hfd);
        chk(irq, 8'h00);
        rd(3'h3, 8'h08);
        wr(3'h3, 8'h02);
        #1 chk(irq, 8'h01);
        wr(3'h3, 8'h03);
        wr(3'h3, 8'h07);
        rd(3'h6, 8'h03);
        chk(irq, 8'h01);
        pin_to(8'hfc);
        wr(3'h3, 8'h07);
        #1 chk(irq, 8'h00);
        wr(3'h7, 8'h03);
        #1 chk(irq, 8'h01);
        rd(3'h7, 8'h03);
        rd(3'h6, 8'h01);
        chk(irq, 8'h00);
        @(posedge clk);
        direction_bits <= 8'hff;
        repeat (2) @(posedge clk);
        #1 chk(sl, 8'hff);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk(pu | pd | sl | dr, 8'h00);
        chk(irq, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        direction_bits <= 8'h00;
        rd(3'h1, 8'h00);
        print_verdict;
    end
endmodule // port_b_pin_control_irq_bench
`default_nettype wire
